// ### src/rtcp_port.sv
`timescale 1ns/1ps
module rtcp_port (
    input wire logic REF_CLK, // Block clock, 20 MHz
    input wire logic RST_N, // Synchronous reset, active low
    input wire logic CLK_EN, // Freezes all state while low
    input wire logic CE_PIN, // Chip enable from host
    input wire logic SCLK_PIN, // Serial clock from host
    input wire logic SDA_IN, // Data pin level
    output logic SDA_OUT, // Data pin drive value
    output logic SDA_OE, // Data pin drive enable, high drives
    input wire logic [55:0] TIME_IN, // Running time bytes 0..6
    output logic CAL_WR_STB, // Pulse: write time bytes
    output logic [6:0] CAL_WR_MASK, // Bytes written by the pulse
    output logic [55:0] CAL_WR_DATA, // Time byte values
    output logic WRITE_PROTECT, // Control register protect bit
    output logic CHARGE_EN, // Charging path enabled
    output logic [1:0] DIODE_COUNT_SELECT, // Diode field copy
    output logic [1:0] SERIES_RESISTOR_SELECT // Resistor field copy
);

    // ********************************************************
    // Helper functions
    // ********************************************************
    // Burst access decode from a command byte
    function automatic logic is_burst(input logic [7:0] cmd);
        is_burst = (cmd[rtcp_pkg::CMD_ADDR_LSB +: rtcp_pkg::CMD_ADDR_W] == rtcp_pkg::BURST_ADDR);
    endfunction : is_burst

    // Next burst index, wrapping at the end of the space
    function automatic logic [4:0] next_idx(input logic [4:0] idx, input logic ram);
        logic [4:0] last;
        last = ram ? rtcp_pkg::RAM_LAST_IDX : rtcp_pkg::CTRL_IDX;
        next_idx = (idx == last) ? 5'h00 : 5'(idx + 5'h01);
    endfunction : next_idx

    // ********************************************************
    // Pin synchronisers and edge detection
    // ********************************************************
    logic [2:0] pins_s; // Synchronised CE, SCLK, SDA
    logic ce_s; // Chip enable level
    logic sclk_s; // Serial clock level
    logic sda_s; // Data level
    logic sclk_d_r; // Serial clock one cycle back
    logic sclk_rise; // Rising serial clock edge
    logic sclk_fall; // Falling serial clock edge

    rtcp_sync #(.WIDTH(3)) u_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .clk_en(CLK_EN),
        .async_in({CE_PIN, SCLK_PIN, SDA_IN}),
        .sync_out(pins_s)
    );

    assign ce_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Previous clock level for edges
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sclk_d_r <= 1'b0;
        end else if (CLK_EN) begin
            sclk_d_r <= sclk_s;
        end
    end

    assign sclk_rise = ce_s && sclk_s && !sclk_d_r;
    assign sclk_fall = ce_s && !sclk_s && sclk_d_r;

    // ********************************************************
    // Storage and state
    // ********************************************************
    rtcp_pkg::rtcp_state_t state_r; // Port state
    logic [2:0] bit_cnt_r; // Bit within current byte
    logic [7:0] shift_r; // Incoming bits, LSB first
    logic [7:0] cmd_r; // Accepted command byte
    logic [4:0] idx_r; // Current register index
    logic [7:0] tx_r; // Byte being sent
    logic [55:0] snap_r; // Time copy for clock burst reads
    logic [7:0] ram_mem [0:rtcp_pkg::RAM_DEPTH-1]; // User RAM
    logic [7:0] cbuf_r [0:rtcp_pkg::CLK_BURST_BYTES-1]; // Clock burst bytes
    logic wp_r; // Write protect
    logic [7:0] trickle_charge_config_r; // Trickle charge configuration

    logic [7:0] byte_in; // Byte completed on this rise
    logic byte_done; // A byte ends on this rise
    logic cmd_done; // Command byte ends on this rise
    logic wr_done; // Data byte ends during write
    logic wr_ram; // Write targets RAM
    logic wr_burst; // Write is a burst
    logic rd_ram; // Read source space
    logic [4:0] rd_idx; // Read source index
    logic rd_snap; // Read from snapshot
    logic [55:0] time_src; // Time bytes for reads
    logic [7:0] rd_byte; // Fetched read byte

    assign byte_in = {sda_s, shift_r[7:1]};
    assign byte_done = sclk_rise && (bit_cnt_r == rtcp_pkg::LAST_BIT);
    assign cmd_done = byte_done && (state_r == rtcp_pkg::ST_CMD);
    assign wr_done = byte_done && (state_r == rtcp_pkg::ST_WR);
    assign wr_ram = cmd_r[rtcp_pkg::CMD_RAM_BIT];
    assign wr_burst = is_burst(cmd_r);

    // ********************************************************
    // Read byte fetch
    // ********************************************************
    // Source selection for the next byte to send
    always_comb begin
        if (state_r == rtcp_pkg::ST_CMD) begin
            rd_ram = byte_in[rtcp_pkg::CMD_RAM_BIT];
            rd_idx = is_burst(byte_in) ? 5'h00 :
                     byte_in[rtcp_pkg::CMD_ADDR_LSB +: rtcp_pkg::CMD_ADDR_W];
            rd_snap = 1'b0; // Snapshot equals live time now
        end else begin
            rd_ram = cmd_r[rtcp_pkg::CMD_RAM_BIT];
            // Single read repeats its byte, burst advances
            rd_idx = is_burst(cmd_r) ? next_idx(idx_r, rd_ram) : idx_r;
            rd_snap = is_burst(cmd_r) && !rd_ram;
        end
    end

    assign time_src = rd_snap ? snap_r : TIME_IN;

    // Register mux, empty locations read zero
    always_comb begin
        rd_byte = 8'h00;
        if (rd_ram) begin
            if (rd_idx <= rtcp_pkg::RAM_LAST_IDX) begin
                rd_byte = ram_mem[rd_idx];
            end
        end else if (rd_idx <= rtcp_pkg::TIME_LAST_IDX) begin
            rd_byte = time_src[{rd_idx[2:0], 3'h0} +: 8];
        end else if (rd_idx == rtcp_pkg::CTRL_IDX) begin
            rd_byte = {wp_r, 7'h00};
        end else if (rd_idx == rtcp_pkg::TRICKLE_IDX && !is_burst(cmd_r) && state_r != rtcp_pkg::ST_CMD) begin
            rd_byte = trickle_charge_config_r;
        end else if (rd_idx == rtcp_pkg::TRICKLE_IDX && state_r == rtcp_pkg::ST_CMD && !is_burst(byte_in)) begin
            rd_byte = trickle_charge_config_r;
        end
    end

    // ********************************************************
    // Port state machine
    // ********************************************************
    // Framing, bit counting and byte sequencing
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_r <= rtcp_pkg::ST_IDLE;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            idx_r <= 5'h00;
            tx_r <= 8'h00;
        end else if (CLK_EN) begin
            if (!ce_s) begin
                state_r <= rtcp_pkg::ST_IDLE;
                bit_cnt_r <= 3'h0;
            end else begin
                if (sclk_rise) begin
                    shift_r <= byte_in;
                    bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
                end
                case (state_r)
                    rtcp_pkg::ST_IDLE: begin
                        // Host holds SCLK low here, so no stray edge
                        state_r <= rtcp_pkg::ST_CMD;
                        bit_cnt_r <= 3'h0;
                    end
                    rtcp_pkg::ST_CMD: begin
                        if (cmd_done) begin
                            cmd_r <= byte_in;
                            idx_r <= rd_idx;
                            if (byte_in[rtcp_pkg::CMD_READ_BIT]) begin
                                tx_r <= rd_byte;
                                state_r <= rtcp_pkg::ST_RD;
                            end else if (!byte_in[rtcp_pkg::CMD_VALID_BIT]) begin
                                state_r <= rtcp_pkg::ST_DONE;
                            end else begin
                                state_r <= rtcp_pkg::ST_WR;
                            end
                        end
                    end
                    rtcp_pkg::ST_RD: begin
                        if (byte_done) begin
                            tx_r <= rd_byte;
                            idx_r <= rd_idx;
                        end
                    end
                    rtcp_pkg::ST_WR: begin
                        if (wr_done) begin
                            if (!wr_burst) begin
                                state_r <= rtcp_pkg::ST_DONE;
                            end else if (wr_ram && idx_r == rtcp_pkg::RAM_LAST_IDX) begin
                                state_r <= rtcp_pkg::ST_DONE;
                            end else if (!wr_ram && idx_r == rtcp_pkg::CTRL_IDX) begin
                                state_r <= rtcp_pkg::ST_DONE;
                            end else begin
                                idx_r <= next_idx(idx_r, wr_ram);
                            end
                        end
                    end
                    rtcp_pkg::ST_DONE: begin
                        // Further clocks ignored until enable falls
                        state_r <= rtcp_pkg::ST_DONE;
                    end
                    default: begin
                        state_r <= rtcp_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ********************************************************
    // Data pin drive
    // ********************************************************
    // Launch on falling edge, release on rising edge
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (CLK_EN) begin
            if (!ce_s || state_r != rtcp_pkg::ST_RD) begin
                SDA_OE <= 1'b0;
            end else if (sclk_rise) begin
                SDA_OE <= 1'b0;
            end else if (sclk_fall) begin
                SDA_OUT <= tx_r[bit_cnt_r];
                SDA_OE <= 1'b1;
            end
        end
    end

    // ********************************************************
    // Clock burst read snapshot
    // ********************************************************
    // Copy the running time when a clock burst read starts
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            snap_r <= '0;
        end else if (CLK_EN) begin
            if (cmd_done && byte_in[rtcp_pkg::CMD_READ_BIT] && is_burst(byte_in)
                && !byte_in[rtcp_pkg::CMD_RAM_BIT]) begin
                snap_r <= TIME_IN;
            end
        end
    end

    // ********************************************************
    // RAM writes
    // ********************************************************
    // Each completed byte goes straight to RAM unless write protect is set
    always_ff @(posedge REF_CLK) begin
        if (CLK_EN && wr_done && wr_ram && !wp_r && idx_r <= rtcp_pkg::RAM_LAST_IDX) begin
            ram_mem[idx_r] <= byte_in;
        end
    end

    // ********************************************************
    // Clock burst gathering
    // ********************************************************
    // Bytes held until the eighth arrives
    always_ff @(posedge REF_CLK) begin
        if (CLK_EN && wr_done && !wr_ram && wr_burst) begin
            cbuf_r[idx_r[2:0]] <= byte_in;
        end
    end

    // ********************************************************
    // Control and trickle registers
    // ********************************************************
    logic clk_burst_commit; // Eighth clock burst byte, unprotected
    logic single_clk_wr; // Single write into clock space

    assign clk_burst_commit = wr_done && !wr_ram && wr_burst && idx_r == rtcp_pkg::CTRL_IDX && !wp_r;
    assign single_clk_wr = wr_done && !wr_ram && !wr_burst;

    // Write protect: control itself stays writable by single writes
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            wp_r <= rtcp_pkg::CTRL_RST[rtcp_pkg::WP_BIT];
        end else if (CLK_EN) begin
            if (clk_burst_commit) begin
                wp_r <= byte_in[rtcp_pkg::WP_BIT];
            end else if (single_clk_wr && idx_r == rtcp_pkg::CTRL_IDX) begin
                wp_r <= byte_in[rtcp_pkg::WP_BIT];
            end
        end
    end

    // Trickle config: single writes only
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            trickle_charge_config_r <= rtcp_pkg::TRICKLE_RST;
        end else if (CLK_EN) begin
            if (single_clk_wr && idx_r == rtcp_pkg::TRICKLE_IDX && !wp_r) begin
                trickle_charge_config_r <= byte_in;
            end
        end
    end

    // Charging decode, registered
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            CHARGE_EN <= 1'b0;
            DIODE_COUNT_SELECT <= rtcp_pkg::TRICKLE_RST[rtcp_pkg::DIODE_LSB +: 2];
            SERIES_RESISTOR_SELECT <= rtcp_pkg::TRICKLE_RST[rtcp_pkg::RES_LSB +: 2];
            WRITE_PROTECT <= 1'b0;
        end else if (CLK_EN) begin
            CHARGE_EN <= (trickle_charge_config_r[rtcp_pkg::KEY_LSB +: 4] == rtcp_pkg::KEY_ON) &&
                         (trickle_charge_config_r[rtcp_pkg::DIODE_LSB +: 2] == rtcp_pkg::DIODE_ONE ||
                          trickle_charge_config_r[rtcp_pkg::DIODE_LSB +: 2] == rtcp_pkg::DIODE_TWO);
            DIODE_COUNT_SELECT <= trickle_charge_config_r[rtcp_pkg::DIODE_LSB +: 2];
            SERIES_RESISTOR_SELECT <= trickle_charge_config_r[rtcp_pkg::RES_LSB +: 2];
            WRITE_PROTECT <= wp_r;
        end
    end

    // ********************************************************
    // Time byte writes to calendar logic
    // ********************************************************
    logic [55:0] cbuf_flat; // Gathered time bytes 0..6

    genvar gb;
    generate
        for (gb = 0; gb < rtcp_pkg::TIME_BYTES; gb++) begin : g_flat
            assign cbuf_flat[gb*8 +: 8] = cbuf_r[gb];
        end
    endgenerate

    // One strobe per accepted single time byte write or full clock burst
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            CAL_WR_STB <= 1'b0;
            CAL_WR_MASK <= 7'h00;
            CAL_WR_DATA <= '0;
        end else if (CLK_EN) begin
            CAL_WR_STB <= 1'b0;
            if (clk_burst_commit) begin
                CAL_WR_STB <= 1'b1;
                CAL_WR_MASK <= 7'h7F;
                CAL_WR_DATA <= cbuf_flat;
            end else if (single_clk_wr && !wp_r && idx_r <= rtcp_pkg::TIME_LAST_IDX) begin
                CAL_WR_STB <= 1'b1;
                CAL_WR_MASK <= 7'(7'h01 << idx_r[2:0]);
                CAL_WR_DATA <= {7{byte_in}};
            end
        end
    end

endmodule : rtcp_port

// ### src/rtcp_pkg.sv
package rtcp_pkg;

    // ********************************************************
    // Command byte layout
    // ********************************************************
    localparam int CMD_VALID_BIT = 7; // Must be one for writes
    localparam int CMD_RAM_BIT = 6; // Zero clock space, one RAM space
    localparam int CMD_ADDR_LSB = 1; // Address field low bit
    localparam int CMD_ADDR_W = 5; // Address field width
    localparam int CMD_READ_BIT = 0; // Zero write, one read
    localparam logic [4:0] BURST_ADDR = 5'h1F; // Address of burst access

    // ********************************************************
    // Register space
    // ********************************************************
    localparam logic [4:0] TIME_LAST_IDX = 5'h06; // Last time/calendar byte
    localparam logic [4:0] CTRL_IDX = 5'h07; // Control register
    localparam logic [4:0] TRICKLE_IDX = 5'h08; // Trickle charge configuration
    localparam logic [4:0] RAM_LAST_IDX = 5'h1E; // Last RAM byte (30)
    localparam int RAM_DEPTH = 31; // RAM bytes
    localparam int TIME_BYTES = 7; // Bytes owned by calendar logic
    localparam int CLK_BURST_BYTES = 8; // Bytes in a clock burst
    localparam int WP_BIT = 7; // Write protect position in control
    localparam logic [7:0] CTRL_RST = 8'h00; // Control after reset
    localparam logic [7:0] TRICKLE_RST = 8'h5C; // Trickle config after reset

    // ********************************************************
    // Trickle register fields
    // ********************************************************
    localparam int KEY_LSB = 4; // Charge enable key position
    localparam int DIODE_LSB = 2; // Diode count select position
    localparam int RES_LSB = 0; // Series resistor select position
    localparam logic [3:0] KEY_ON = 4'hA; // Only pattern that enables
    localparam logic [1:0] DIODE_ONE = 2'h1; // One diode
    localparam logic [1:0] DIODE_TWO = 2'h2; // Pair of diode drops

    // ********************************************************
    // Serial timing
    // ********************************************************
    localparam logic [2:0] LAST_BIT = 3'h7; // Bit index of a byte's last bit
    localparam int SYNC_STAGES = 2; // Flip-flops on each pin input

    // Port state machine
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_RD,
        ST_WR,
        ST_DONE
    } rtcp_state_t;

endpackage : rtcp_pkg

// ### src/rtcp_sync.sv
`timescale 1ns/1ps
module rtcp_sync #(
    parameter int WIDTH = 3 // Number of pin inputs
) (
    input wire logic clk, // Sampling clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic clk_en, // Freezes the stages while low
    input wire logic [WIDTH-1:0] async_in, // Raw pin levels
    output logic [WIDTH-1:0] sync_out // Levels after two stages
);

    // ********************************************************
    // Two flip-flop synchroniser per bit
    // ********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [rtcp_pkg::SYNC_STAGES-1:0] stage_r; // Stage chain
            // First stage feeds only the second stage
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    stage_r <= '0;
                end else if (clk_en) begin
                    stage_r <= {stage_r[rtcp_pkg::SYNC_STAGES-2:0], async_in[gi]};
                end
            end
            assign sync_out[gi] = stage_r[rtcp_pkg::SYNC_STAGES-1];
        end
    endgenerate

endmodule : rtcp_sync

// ### tb/rtcp_port_asserts.sv
`timescale 1ns/1ps
module rtcp_asserts (
    input wire logic REF_CLK, // Block clock
    input wire logic RST_N, // Reset, active low
    input wire logic CE_PIN, // Chip enable
    input wire logic SCLK_PIN, // Serial clock
    input wire logic SDA_OUT, // Data drive value
    input wire logic SDA_OE, // Data drive enable
    input wire logic CAL_WR_STB, // Time write pulse
    input wire logic [6:0] CAL_WR_MASK, // Time write lanes
    input wire logic WRITE_PROTECT, // Protect bit
    input wire logic CHARGE_EN, // Charging on
    input wire logic [1:0] DIODE_COUNT_SELECT // Diode field
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // ********************************************************
    // Pin behaviour
    // ********************************************************
    property p_idle_hiz; !CE_PIN [*6] |-> !SDA_OE; endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("pin driven while idle");
    property p_oe_on_fall; $rose(SDA_OE) |-> !$past(SCLK_PIN, 2) && CE_PIN; endproperty
    a_oe_on_fall: assert property (p_oe_on_fall) else $error("drive not after fall");
    property p_out_stable; SDA_OE && $past(SDA_OE) |-> $stable(SDA_OUT); endproperty
    a_out_stable: assert property (p_out_stable) else $error("bit moved while driven");
    property p_rise_release; $rose(SCLK_PIN) |-> ##[1:6] !SDA_OE; endproperty
    a_rise_release: assert property (p_rise_release) else $error("pin kept after rise");
    // ********************************************************
    // Write side effects
    // ********************************************************
    property p_stb_pulse; CAL_WR_STB |=> !CAL_WR_STB; endproperty
    a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
    property p_stb_wp; CAL_WR_STB |-> !$past(WRITE_PROTECT); endproperty
    a_stb_wp: assert property (p_stb_wp) else $error("write while protected");
    property p_mask; CAL_WR_STB |-> ($onehot(CAL_WR_MASK) || CAL_WR_MASK == 7'h7F); endproperty
    a_mask: assert property (p_mask) else $error("bad write lanes");
    property p_charge; CHARGE_EN |-> DIODE_COUNT_SELECT inside {2'h1, 2'h2}; endproperty
    a_charge: assert property (p_charge) else $error("charge with bad diode");
    c_burst: cover property (CAL_WR_STB && CAL_WR_MASK == 7'h7F);
    c_read: cover property ($rose(SDA_OE));
    c_chg: cover property ($rose(CHARGE_EN));
endmodule : rtcp_asserts

// ### tb/rtcp_host.sv
`timescale 1ns/1ps
module rtcp_host (
    input wire logic clk, // Block clock
    input wire logic dev_out, // Device drive value
    input wire logic dev_oe, // Device drive enable
    output logic ce = 1'b0, // Chip enable
    output logic sclk = 1'b0, // Serial clock, parked low
    output logic sda // Resolved data wire
);
    logic hv = 1'b0; // Host drive value
    logic hen = 1'b0; // Host drive enable
    logic q = 1'b0; // Previous wire level
    // Released wire toggles so a stale bit never passes
    assign sda = dev_oe ? dev_out : (hen ? hv : ~q);
    always @(posedge clk) q <= sda;
    // Frame start with clock held low
    task start();
        sclk <= 1'b0;
        ce <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : start
    // Frame end, wire released
    task stop();
        ce <= 1'b0;
        sclk <= 1'b0;
        hen <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : stop
    // Send n bits LSB first, held across each rise
    task send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            sclk <= 1'b0;
            hv <= b[i];
            hen <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask : send
    // Receive a byte LSB first, sampled in high phase
    task recv(output logic [7:0] b);
        hen <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (2) @(posedge clk);
            #1 b[i] = sda;
            repeat (2) @(posedge clk);
        end
    endtask : recv
endmodule : rtcp_host

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0; // Block clock
    logic rst_n = 1'b0; // Reset, active low
    logic clk_en = 1'b1; // Clock enable, low freezes the port
    logic ce, sclk, sda, sda_out, sda_oe, stb, wp, chg; // Pins and flags
    logic [6:0] mask; // Time write lanes
    logic [55:0] wdata; // Time write data
    logic [55:0] time_in = 56'h66554433221100; // Running time
    logic [1:0] dsel, rsel; // Trickle field copies
    logic [7:0] rd; // Last byte read
    logic [8:0] tv[6] = '{9'h1A5, 9'h1AB, 9'h0AC, 9'h0B5, 9'h0A0, 9'h1A6}; // Charge flag, trickle
    int bad_count = 0;
    int total_checks = 0;
    int stb_cnt = 0; // Time strobes seen
    always #25 ref_clk = ~ref_clk;
    rtcp_port i_rtcp_port (.REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(clk_en), .CE_PIN(ce), .SCLK_PIN(sclk),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TIME_IN(time_in), .CAL_WR_STB(stb),
        .CAL_WR_MASK(mask), .CAL_WR_DATA(wdata), .WRITE_PROTECT(wp), .CHARGE_EN(chg),
        .DIODE_COUNT_SELECT(dsel), .SERIES_RESISTOR_SELECT(rsel));
    rtcp_host i_rtcp_host (.clk(ref_clk), .dev_out(sda_out), .dev_oe(sda_oe), .ce(ce), .sclk(sclk), .sda(sda));
    // Count time strobes
    always @(posedge ref_clk) if (stb === 1'b1) stb_cnt <= stb_cnt + 1;
    task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
            bad_count++;
        end
    endtask : chk
    task wreg(input logic [7:0] cmd, input logic [7:0] d);
        i_rtcp_host.start();
        i_rtcp_host.send(cmd, 8);
        i_rtcp_host.send(d, 8);
        i_rtcp_host.stop();
    endtask : wreg
    task rchk(input string what, input logic [7:0] cmd, input logic [7:0] exp);
        i_rtcp_host.start();
        i_rtcp_host.send(cmd, 8);
        i_rtcp_host.recv(rd);
        i_rtcp_host.stop();
        chk(what, exp, rd);
    endtask : rchk
    // Clock burst write of n bytes, control as byte 7
    task cburst(input int n, input logic [7:0] ctl);
        i_rtcp_host.start();
        i_rtcp_host.send(8'hBE, 8);
        for (int i = 0; i < n; i++) i_rtcp_host.send((i == 7) ? ctl : 8'h10 + 8'(i), 8);
        i_rtcp_host.stop();
    endtask : cburst
    task tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hung transfer
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("diode reset", 2'h3, dsel);
        rchk("trickle reset", 8'h91, 8'h5C);
        foreach (tv[i]) begin
            wreg(8'h90, tv[i][7:0]);
            chk("charge", tv[i][8], chg);
            chk("diode", tv[i][3:2], dsel);
            chk("resistor", tv[i][1:0], rsel);
        end
        wreg(8'hCA, 8'h35);
        wreg(8'h4A, 8'hFF);
        i_rtcp_host.start();
        i_rtcp_host.send(8'hCA, 8);
        i_rtcp_host.send(8'h11, 5);
        i_rtcp_host.stop();
        i_rtcp_host.start();
        i_rtcp_host.send(8'hCB, 8);
        i_rtcp_host.recv(rd);
        chk("ram5", 8'h35, rd);
        i_rtcp_host.recv(rd);
        chk("ram5 repeat", 8'h35, rd);
        i_rtcp_host.stop();
        i_rtcp_host.start();
        i_rtcp_host.send(8'hFE, 8);
        for (int i = 0; i < 3; i++) i_rtcp_host.send(8'hA0 + 8'(i), 8);
        i_rtcp_host.stop();
        i_rtcp_host.start();
        i_rtcp_host.send(8'hFF, 8);
        for (int i = 0; i < 3; i++) begin
            i_rtcp_host.recv(rd);
            chk("ram burst", 8'hA0 + 8'(i), rd);
        end
        i_rtcp_host.stop();
        cburst(5, 8'h00);
        chk("short burst", 0, stb_cnt);
        cburst(9, 8'h00);
        chk("burst strobes", 1, stb_cnt);
        chk("burst lanes", 7'h7F, mask);
        chk("burst data", 56'h16151413121110, wdata);
        chk("trickle kept", 1'b1, chg);
        // Frozen port must miss a whole frame
        clk_en <= 1'b0;
        wreg(8'h90, 8'h00);
        clk_en <= 1'b1;
        chk("frozen trickle", 1'b1, chg);
        i_rtcp_host.start();
        i_rtcp_host.send(8'hBF, 8);
        for (int i = 0; i < 8; i++) begin
            i_rtcp_host.recv(rd);
            time_in <= 56'hEEEEEEEEEEEEEE;
            chk("snapshot", (i == 7) ? 0 : i * 17, rd);
        end
        i_rtcp_host.stop();
        rchk("time live", 8'h85, 8'hEE);
        i_rtcp_host.start();
        i_rtcp_host.send(8'h84, 8);
        i_rtcp_host.send(8'h59, 8);
        i_rtcp_host.send(8'h00, 8);
        i_rtcp_host.stop();
        chk("single strobe", 2, stb_cnt);
        chk("single lane", 7'h04, mask);
        chk("single data", {7{8'h59}}, wdata);
        wreg(8'h8E, 8'h80);
        chk("protect on", 1'b1, wp);
        wreg(8'hCA, 8'h77);
        wreg(8'h84, 8'h00);
        cburst(8, 8'h00);
        chk("protected strobes", 2, stb_cnt);
        chk("protect kept", 1'b1, wp);
        rchk("ram5 protected", 8'hCB, 8'h35);
        wreg(8'h8E, 8'h00);
        chk("protect off", 1'b0, wp);
        wreg(8'h92, 8'hAA);
        rchk("empty slot", 8'h93, 8'h00);
        tally_and_finish();
    end
endmodule : tb
bind rtcp_port rtcp_asserts i_rtcp_asserts (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE_PIN(CE_PIN),
    .SCLK_PIN(SCLK_PIN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CAL_WR_STB(CAL_WR_STB),
    .CAL_WR_MASK(CAL_WR_MASK), .WRITE_PROTECT(WRITE_PROTECT), .CHARGE_EN(CHARGE_EN),
    .DIODE_COUNT_SELECT(DIODE_COUNT_SELECT));
